// ### rtl/spirf_pkg.sv
package spirf_pkg;

   // Frame geometry
   localparam int FRAME_BITS = 32;
   localparam logic [5:0] FRAME_BITS_CNT = 6'h20;
   localparam logic [5:0] CNT_SAT = 6'h3F;
   localparam int CMD_MSB = 31;
   localparam int CMD_LSB = 28;
   localparam int FIX_MSB = 27;
   localparam int FIX_LSB = 24;
   localparam int WADDR_MSB = 23;
   localparam int WADDR_LSB = 17;
   localparam int RDAT_MSB = 15;
   localparam int RDAT_LSB = 8;

   // Command and response codes
   localparam logic [3:0] CMD_REG_READ = 4'hC;
   localparam logic [3:0] RSP_REG_READ = 4'h6;
   localparam logic [3:0] RSP_ERROR = 4'h0;
   localparam logic [1:0] ST_ERROR = 2'h3;
   localparam logic [1:0] SF_SPI_ERR = 2'h1;
   localparam logic [1:0] SF_MISO_ERR = 2'h2;
   localparam logic [1:0] SF_UNSUPPORTED = 2'h3;
   localparam logic [31:0] TX_RESET = 32'h0000_0000;

   // Check byte, MSB first over bits 31:8
   localparam logic [7:0] CRC_POLY = 8'h2F;
   localparam logic [7:0] CRC_SEED = 8'hFF;

   typedef struct packed {
      logic [3:0] cmd;
      logic [1:0] status;
      logic [1:0] unused;
      logic [15:0] data;
      logic [7:0] crc;
   } spirf_frame_t;

   typedef enum logic [0:0] {
      SPIRF_IDLE = 1'b0,
      SPIRF_FETCH = 1'b1
   } spirf_state_t;

   function automatic logic [7:0] spirf_crc8(input logic [23:0] d);
      logic [7:0] c;
      c = CRC_SEED;
      for (int i = 23; i >= 0; i--) begin
         if (c[7] ^ d[i]) begin
            c = {c[6:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

endpackage

// ### rtl/spirf_pair_mem.sv
`timescale 1ns/100ps
`default_nettype none
module spirf_pair_mem (
   input wire logic mclk,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   input wire logic [6:0] rd_word,
   output logic [15:0] rd_pair
);
   logic [7:0] even_byte [0:127];
   logic [7:0] odd_byte [0:127];

   // Bit 0 of the address picks the half of the pair
   always_ff @(posedge mclk) begin
      if (wr_en && wr_addr[0]) begin
         odd_byte[wr_addr[7:1]] <= wr_data;
      end
      if (wr_en && !wr_addr[0]) begin
         even_byte[wr_addr[7:1]] <= wr_data;
      end
      if (rd_en) begin
         rd_pair <= {odd_byte[rd_word], even_byte[rd_word]};
      end
   end
endmodule // spirf_pair_mem
`default_nettype wire

// ### rtl/spirf_spi_read_frames.sv
`timescale 1ns/100ps
`default_nettype none
module spirf_spi_read_frames
   import spirf_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic miso_readback,
   output logic miso_out,
   output logic miso_oe,
   input wire logic ext_spi_error,
   input wire logic [1:0] basic_status,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   output logic read_done,
   output logic reply_error
);
   // Link domain
   logic [31:0] rx_word, next_rx_word;
   logic [5:0] rx_cnt, next_rx_cnt;
   logic mism, next_mism;
   logic fresh, next_fresh;
   logic [4:0] fall_cnt, next_fall_cnt;
   logic tx_bit;
   logic [31:0] tx_word;

   // Only the first rising edge of a frame sees it set
   always_comb begin
      next_fresh = 1'b0;
   end

   // Select high marks the next rising edge as a frame start
   always_ff @(posedge sclk or posedge ss_n) begin
      if (ss_n) begin
         fresh <= 1'b1;
      end else begin
         fresh <= next_fresh;
      end
   end

   always_comb begin
      next_fall_cnt = fall_cnt + 5'h01;
   end

   // Bit index only advances on falling edges, so MSB is out before the first rise
   always_ff @(negedge sclk or posedge ss_n) begin
      if (ss_n) begin
         fall_cnt <= 5'h00;
      end else begin
         fall_cnt <= next_fall_cnt;
      end
   end

   // Tx word only changes between frames, so it is stable while sclk runs
   assign tx_bit = tx_word[5'd31 - fall_cnt];
   assign miso_out = tx_bit;
   assign miso_oe = ~ss_n;

   always_comb begin
      next_rx_word = fresh ? {31'h0000_0000, mosi} : {rx_word[30:0], mosi};
      next_rx_cnt = fresh ? 6'h01 : ((rx_cnt == CNT_SAT) ? CNT_SAT : rx_cnt + 6'h01);
      next_mism = (fresh ? 1'b0 : mism) | (miso_readback != tx_bit);
   end

   // Results freeze when sclk stops; mclk reads them after select is synced
   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         rx_word <= 32'h0000_0000;
         rx_cnt <= 6'h00;
         mism <= 1'b0;
      end else begin
         rx_word <= next_rx_word;
         rx_cnt <= next_rx_cnt;
         mism <= next_mism;
      end
   end

   // Main domain
   logic ss_s1, ss_s2, ss_prev;
   logic next_ss_s1, next_ss_s2, next_ss_prev;
   logic err_s1, err_s2;
   logic next_err_s1, next_err_s2;
   logic frame_end;
   logic cmd_read, bad_len, bad_fix, bad_data;
   logic [1:0] detail;
   spirf_state_t state, next_state;
   logic is_read, next_is_read;
   logic err_spi, next_err_spi;
   logic err_miso, next_err_miso;
   logic [31:0] next_tx_word;
   logic next_read_done, next_reply_error;
   logic rd_en;
   logic [15:0] rd_pair;
   spirf_frame_t rsp;

   // Select and the external error come from other clocks: two flops each
   always_comb begin
      next_ss_s1 = ss_n;
      next_ss_s2 = ss_s1;
      next_ss_prev = ss_s2;
      next_err_s1 = ext_spi_error;
      next_err_s2 = err_s1;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ss_s1 <= 1'b1;
         ss_s2 <= 1'b1;
         ss_prev <= 1'b1;
         err_s1 <= 1'b0;
         err_s2 <= 1'b0;
      end else begin
         ss_s1 <= next_ss_s1;
         ss_s2 <= next_ss_s2;
         ss_prev <= next_ss_prev;
         err_s1 <= next_err_s1;
         err_s2 <= next_err_s2;
      end
   end

   assign frame_end = ss_s2 & ~ss_prev;
   assign rd_en = frame_end & (state == SPIRF_IDLE);

   // Link results are frozen by now: select has been high for two mclk edges
   assign cmd_read = (rx_word[CMD_MSB:CMD_LSB] == CMD_REG_READ);
   assign bad_len = (rx_cnt != FRAME_BITS_CNT);
   assign bad_fix = (rx_word[FIX_MSB:FIX_LSB] != 4'h0);
   assign bad_data = cmd_read && (rx_word[RDAT_MSB:RDAT_LSB] != 8'h00);
   // SPI error outranks an output mismatch in the detail code
   assign detail = err_spi ? SF_SPI_ERR : (err_miso ? SF_MISO_ERR : SF_UNSUPPORTED);

   // Pair is captured right at the end of the command frame
   spirf_pair_mem u_mem (
      .mclk(mclk),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_en(rd_en),
      .rd_word(rx_word[WADDR_MSB:WADDR_LSB]),
      .rd_pair(rd_pair)
   );

   // Reply frame from the flags latched at frame end
   always_comb begin
      rsp = '0;
      if (err_spi || err_miso || !is_read) begin
         rsp.cmd = RSP_ERROR;
         rsp.status = ST_ERROR;
         rsp.unused = 2'h0;
         rsp.data = {14'h0000, detail};
      end else begin
         rsp.cmd = RSP_REG_READ;
         rsp.status = basic_status;
         rsp.unused = 2'h0;
         rsp.data = rd_pair;
      end
      rsp.crc = spirf_crc8(rsp[31:8]);
   end

   // Host must leave select high four mclk so the reply is ready in time
   always_comb begin
      next_state = state;
      next_is_read = is_read;
      next_err_spi = err_spi;
      next_err_miso = err_miso;
      next_tx_word = tx_word;
      next_read_done = 1'b0;
      next_reply_error = reply_error;
      unique case (state)
         SPIRF_IDLE: begin
            if (frame_end) begin
               next_state = SPIRF_FETCH;
               next_is_read = cmd_read;
               next_err_spi = bad_len || err_s2 || bad_fix || bad_data;
               next_err_miso = mism;
            end
         end
         SPIRF_FETCH: begin
            next_state = SPIRF_IDLE;
            next_tx_word = rsp;
            next_read_done = is_read && !err_spi && !err_miso;
            next_reply_error = err_spi || err_miso || !is_read;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= SPIRF_IDLE;
         is_read <= 1'b0;
         err_spi <= 1'b0;
         err_miso <= 1'b0;
         tx_word <= TX_RESET;
         read_done <= 1'b0;
         reply_error <= 1'b0;
      end else begin
         state <= next_state;
         is_read <= next_is_read;
         err_spi <= next_err_spi;
         err_miso <= next_err_miso;
         tx_word <= next_tx_word;
         read_done <= next_read_done;
         reply_error <= next_reply_error;
      end
   end
endmodule // spirf_spi_read_frames
`default_nettype wire

// ### dv/spirf_checker_props.sv
`timescale 1ns/100ps
`default_nettype none
module spirf_checker (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ss_n,
   input wire logic ext_spi_error,
   input wire logic miso_out,
   input wire logic miso_oe,
   input wire logic read_done,
   input wire logic reply_error
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   oe_follow_a: assert property (miso_oe == !ss_n) else $error("oe off");
   done_pulse_a: assert property (read_done |=> !read_done) else $error("done long");
   done_idle_a: assert property (read_done |-> ss_n) else $error("done in frame");
   done_good_a: assert property (read_done |-> !reply_error) else $error("done with error");
   spi_err_a: assert property ($rose(ss_n) && ext_spi_error |-> ##[3:6] reply_error) else $error("no err");
   no_reply_a: assert property ($rose(ss_n) && ext_spi_error |-> !read_done [*6]) else $error("reply");
   err_steady_a: assert property (!ss_n [*3] |-> $stable(reply_error)) else $error("err moved");
   first_bit_a: assert property ($fell(ss_n) |-> !miso_out) else $error("bit31 set");
endmodule // spirf_checker
bind spirf_spi_read_frames spirf_checker chk (.mclk(mclk), .nrst(nrst), .ss_n(ss_n),
   .ext_spi_error(ext_spi_error), .miso_out(miso_out), .miso_oe(miso_oe), .read_done(read_done),
   .reply_error(reply_error));
`default_nettype wire

// ### dv/spirf_host.sv
`timescale 1ns/100ps
`default_nettype none
module spirf_host (
   output logic sclk,
   output logic ss_n,
   output logic mosi,
   input wire logic miso
);
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b1;
   end
   task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
      ss_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         mosi = cmd[i];
         #16 sclk = 1'b1;
         rsp[i] = miso;
         #16 sclk = 1'b0;
      end
      #16 ss_n = 1'b1;
      mosi = ~mosi; // No stale bit once released
   endtask
endmodule // spirf_host
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic sclk, ss_n, mosi, miso_out, miso_oe, read_done, reply_error;
   logic ext_spi_error = 1'b0;
   logic flip = 1'b0;
   logic wr_en = 1'b0;
   logic [1:0] basic_status = 2'h0;
   logic [7:0] wr_addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] a;
   logic [7:0] mem [256];
   logic [31:0] seed = 32'h0001_6408;
   logic [31:0] rsp;
   logic [23:0] e = 24'h00_0000;
   logic [31:0] want;
   int num_errors = 0;
   int tests_run = 0;
   int done_seen = 0;
   int done_want = 0;
   // Pull-up on the wire; flip fakes a disturbed line
   wire logic miso_readback = miso_oe ? (miso_out ^ flip) : 1'b1;
   always #10 mclk = ~mclk;
   spirf_spi_read_frames uut (.mclk(mclk), .nrst(nrst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
      .miso_readback(miso_readback), .miso_out(miso_out), .miso_oe(miso_oe), .ext_spi_error(ext_spi_error),
      .basic_status(basic_status), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .read_done(read_done), .reply_error(reply_error));
   spirf_host host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso_out));
   function logic [7:0] rnd8();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   // Pulses last one mclk, so exactly one falling edge sees each of them
   always @(negedge mclk) begin
      if (read_done === 1'b1) begin
         done_seen++;
      end
   end
   function logic [7:0] crc_of(input logic [23:0] d);
      logic [7:0] c;
      c = spirf_pkg::CRC_SEED;
      for (int b = 23; b >= 0; b--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[b]) ? spirf_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction
   // Bits 31:8 of the reply; the check byte is worked out from them
   function logic [23:0] expect_for(input int i, input logic [7:0] ad);
      if (i == 3 || i == 9) return 24'h0C_0001;
      if (i == 5) return 24'h0C_0002;
      if (i == 7) return 24'h0C_0003;
      return {4'h6, basic_status, 2'h0, mem[{ad[7:1], 1'b1}], mem[{ad[7:1], 1'b0}]};
   endfunction
   task end_sim();
      $display("checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      nrst = 1'b1;
      for (int k = 0; k < 256; k++) begin
         @(negedge mclk);
         wr_en = 1'b1;
         wr_addr = k[7:0];
         wr_data = rnd8();
         mem[k] = wr_data;
      end
      for (int i = 0; i < 17; i++) begin
         @(negedge mclk);
         wr_en = 1'b0;
         a = rnd8();
         basic_status = a[1:0];
         ext_spi_error = (i == 3);
         flip = (i == 5);
         a = rnd8();
         host.xfer({(i == 7) ? 4'h8 : 4'hC, 4'h0, a, (i == 9) ? 8'h5A : 8'h00, 8'h00}, rsp);
         // First frame after reset shows the all-zero reply
         want = {e, (i == 0) ? 8'h00 : crc_of(e)};
         tests_run++;
         if (rsp !== want) begin
            num_errors++;
            $display("mismatch at %0t: reply %h, expected %h", $time, rsp, want);
         end
         e = expect_for(i, a);
         if (e[23:20] == 4'h6) begin
            done_want++;
         end
         repeat (10) @(negedge mclk);
         tests_run++;
         if (done_seen !== done_want) begin
            num_errors++;
            $display("mismatch at %0t: %0d replies done, expected %0d", $time, done_seen, done_want);
         end
         tests_run++;
         if (reply_error !== (e[23:20] == 4'h0)) begin
            num_errors++;
            $display("mismatch at %0t: error flag wrong", $time);
         end
         // Overwrite after capture; the queued reply must keep the old byte
         wr_en = 1'b1;
         wr_addr = {a[7:1], 1'b0};
         wr_data = ~mem[wr_addr];
         mem[wr_addr] = wr_data;
      end
      end_sim();
   end
endmodule // tb
`default_nettype wire
